// ===== hw/ufs_pkg.sv
// shared constants, field positions and carrier types of the usb event block
package ufs_pkg;

  // register byte addresses on the bus
  localparam logic [31:0] UFS_ADDR_FRAME  = 32'hfff78004;
  localparam logic [31:0] UFS_ADDR_ENABLE = 32'hfff78010;
  localparam logic [31:0] UFS_ADDR_STATUS = 32'hfff78014;
  localparam logic [31:0] UFS_ADDR_CLEAR  = 32'hfff78018;

  // field positions shared by enable, status and clear registers
  localparam int UFS_BIT_SPEED   = 0;
  localparam int UFS_BIT_SUSPEND = 1;
  localparam int UFS_BIT_USOF    = 2;
  localparam int UFS_BIT_SOF     = 3;
  localparam int UFS_BIT_RSTDONE = 4;
  localparam int UFS_BIT_WAKE    = 5;
  localparam int UFS_BIT_RSMDONE = 6;
  localparam int UFS_BIT_UPRES   = 7;
  localparam int UFS_BIT_EP_LO   = 8;
  localparam int UFS_BIT_DMA_LO  = 25;

  // counts of sources
  localparam int UFS_NUM_EP  = 7;
  localparam int UFS_NUM_DMA = 6;

  // frame count register layout
  localparam int UFS_BIT_FERR    = 31;
  localparam int UFS_FRAME_LO    = 3;
  localparam int UFS_FRAME_W     = 11;
  localparam int UFS_MICRO_W     = 3;

  // mask of bits that exist in enable and status
  localparam logic [31:0] UFS_EVENT_MASK  = 32'h7e007ffe;
  localparam logic [31:0] UFS_CLEAR_MASK  = 32'h000000fe;
  localparam logic [31:0] UFS_ENABLE_RST  = 32'h00000000;

  // timing: clock rate and documented times
  localparam int UFS_CLK_KHZ      = 25000;
  localparam int UFS_SUSPEND_MS   = 3;
  localparam int UFS_MICRO_NS     = 125000;
  localparam int UFS_CLK_NS       = 40;
  localparam int UFS_MICRO_CYCLES = UFS_MICRO_NS / UFS_CLK_NS;
  localparam int UFS_SUSPEND_CYC  = UFS_SUSPEND_MS * UFS_CLK_KHZ;
  localparam int UFS_WAKE_FILTER  = 4;
  localparam logic [2:0] UFS_LAST_MICRO = 3'h7;

  // events reported by the link layer, same clock domain
  typedef struct packed {
    logic                   sof_seen;    // start-of-frame packet received
    logic                   usof_seen;   // micro start-of-frame received
    logic                   crc_bad;     // frame number crc failed, with the above
    logic [UFS_FRAME_W-1:0] frame_num;   // frame number carried by the packet
    logic                   high_speed;  // link runs in high speed
    logic                   bus_reset;   // bus reset in progress, level
    logic                   resume_end;  // good end of host resume, pulse
    logic                   up_resume;   // upstream resume being sent, level
  } ufs_link_t;

  // raw line state from the transceiver, asynchronous
  typedef struct packed {
    logic idle_j;    // line in idle j state
    logic non_idle;  // line carries non-idle signalling
  } ufs_line_t;

endpackage

// ===== hw/ufs_event_ctrl.sv
// usb device event, interrupt and frame status logic with an ahb-lite slave
//
// Behaviour
// - frame number from latest received SOF
// - corrupted frame number sets crc error flag
// - crc flag updates with each received SOF or micro-SOF packet
// - enable bits read back, gate interrupts
// - bus reset end sets its enable
// - dma channel enables at bits 25-30
// - speed bit one in high speed
// - suspend after 3 ms idle j
// - status bits 1-7 record without enable, interrupt needs enable
// - micro-SOF every 125 us, counts microframes
// - micro-SOF and SOF never together
// - SOF every 1 ms, resets microframes
// - end of bus reset sets status
// - wake on filtered non-idle while suspended
// - wake detected even with clock gated
// - end of host resume sets status
// - upstream resume sets status while sending
// - endpoint bit follows enabled endpoint source
// - dma bit follows enabled channel source
// - status read-only, write one clears
// - clear covers wake and resume bits
// - microframe count restarts each frame
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ufs_event_ctrl
  import ufs_pkg::*;
#(
  parameter int SUSPEND_CYCLES = UFS_SUSPEND_CYC,   // idle time before suspend
  parameter int MICRO_CYCLES   = UFS_MICRO_CYCLES   // one microframe period
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic      [31:0]            hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  // link side
  input  wire ufs_link_t              link,
  input  wire ufs_line_t              line,
  input  wire logic                   ctrl_clk_on,
  input  wire logic [UFS_NUM_EP-1:0]  ep_irq,
  input  wire logic [UFS_NUM_DMA-1:0] dma_irq,
  // controller interrupt
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [31:0]            enable_q;       // event enable register
  logic [31:0]            status_q;       // sticky event status
  logic [UFS_FRAME_W-1:0] frame_q;        // last received frame number
  logic [UFS_MICRO_W-1:0] micro_q;        // microframe count inside frame
  logic                   ferr_q;         // frame number crc error
  logic                   addr_ok_q;      // data phase pending
  logic                   wr_q;           // pending transfer is a write
  logic [31:0]            addr_q;         // pending address
  logic [31:0]            rdata_q;        // read data for the data phase
  logic                   irq_q;          // registered interrupt
  logic [1:0]             j_sync_q;       // idle j synchroniser
  logic [1:0]             ni_sync_q;      // non-idle synchroniser
  logic [$clog2(UFS_WAKE_FILTER+1)-1:0] ni_cnt_q;  // non-idle filter
  logic [31:0]            idle_cnt_q;     // idle j duration
  logic                   suspended_q;    // bus in suspend
  logic                   reset_d1_q;     // delayed bus reset level
  logic [31:0]            tick_cnt_q;     // microframe synthesis timer
  logic                   addr_take;      // address phase accepted
  logic                   wr_enable;      // write hits enable register
  logic                   wr_clear;       // write hits clear register
  logic [31:0]            clr_bits;       // bits cleared this cycle
  logic [31:0]            set_bits;       // bits set this cycle
  logic                   sof_ev;         // start-of-frame event
  logic                   usof_ev;        // micro start-of-frame event
  logic                   synth;          // microframe timer expired
  logic                   reset_end;      // falling edge of bus reset
  logic                   wake_ev;        // filtered non-idle in suspend
  logic                   suspend_ev;     // idle long enough
  logic [31:0]            rd_mux;         // read data selection

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always okay

  assign addr_take = hsel & htrans[1] & hready;
  assign wr_enable = addr_ok_q & wr_q & (addr_q == UFS_ADDR_ENABLE);
  assign wr_clear  = addr_ok_q & wr_q & (addr_q == UFS_ADDR_CLEAR);

  // capture of the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ok_q <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= 32'h00000000;
    end else begin
      addr_ok_q <= addr_take;
      wr_q      <= hwrite;
      addr_q    <= haddr;
    end
  end

  // read data is chosen in the address phase and held in the data phase
  always_comb begin
    unique case (haddr)
      UFS_ADDR_ENABLE: rd_mux = enable_q & UFS_EVENT_MASK;
      UFS_ADDR_STATUS: rd_mux = status_q;
      UFS_ADDR_FRAME:  rd_mux = {ferr_q, 17'h00000, frame_q, micro_q};
      default:         rd_mux = 32'h00000000;                  // clear and unmapped
    endcase
  end

  // read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (addr_take && !hwrite) begin
      rdata_q <= rd_mux;
    end
  end

  assign hrdata = rdata_q;

  // ready and response stand constant, from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line state synchronisers and wake filter

  // two-flop synchronisers for the asynchronous line levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      j_sync_q  <= 2'h0;
      ni_sync_q <= 2'h0;
    end else begin
      j_sync_q  <= {j_sync_q[0], line.idle_j};
      ni_sync_q <= {ni_sync_q[0], line.non_idle};
    end
  end

  // non-idle must hold a few cycles before it counts as a wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ni_cnt_q <= '0;
    end else if (!ni_sync_q[1] || !suspended_q) begin
      ni_cnt_q <= '0;
    end else if (ni_cnt_q != UFS_WAKE_FILTER[$bits(ni_cnt_q)-1:0]) begin
      ni_cnt_q <= ni_cnt_q + 1'b1;
    end
  end

  // wake only from the bus, never from our own upstream resume
  assign wake_ev = suspended_q & ~link.up_resume
                 & (ni_cnt_q == UFS_WAKE_FILTER[$bits(ni_cnt_q)-1:0] - 1'b1);

  ////////////////////////////////////////////////////////////////////////////
  // suspend detection

  // count consecutive idle j cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_q <= 32'h00000000;
    end else if (!j_sync_q[1] || suspended_q) begin
      idle_cnt_q <= 32'h00000000;
    end else if (!suspend_ev) begin
      idle_cnt_q <= idle_cnt_q + 32'h00000001;
    end
  end

  assign suspend_ev = !suspended_q && (idle_cnt_q == SUSPEND_CYCLES[31:0] - 32'h1);

  // suspend state, left on a wake, a bus reset or a received SOF or micro-SOF packet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      suspended_q <= 1'b0;
    end else if (suspend_ev) begin
      suspended_q <= 1'b1;
    end else if (wake_ev || link.bus_reset || link.sof_seen || link.usof_seen) begin
      suspended_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame and microframe tracking

  // timer that stands in for a missing microframe packet
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h00000000;
    end else if (link.sof_seen || link.usof_seen || synth || suspended_q) begin
      tick_cnt_q <= 32'h00000000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end

  assign synth = !suspended_q && link.high_speed
               && (tick_cnt_q == MICRO_CYCLES[31:0] - 32'h1);

  // frame start wins, so the two events never share a cycle
  assign sof_ev  = link.sof_seen
                 | (synth & ~link.usof_seen & (micro_q == UFS_LAST_MICRO));
  assign usof_ev = ~sof_ev & (link.usof_seen
                 | (synth & (micro_q != UFS_LAST_MICRO)));

  // frame number, microframe count and crc flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_q <= '0;
      micro_q <= '0;
      ferr_q  <= 1'b0;
    end else if (link.sof_seen) begin
      frame_q <= link.frame_num;
      micro_q <= '0;
      ferr_q  <= link.crc_bad;
    end else if (usof_ev && link.usof_seen) begin
      micro_q <= micro_q + 1'b1;
      ferr_q  <= link.crc_bad;
    end else if (sof_ev) begin
      micro_q <= '0;
    end else if (usof_ev) begin
      micro_q <= micro_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus reset edge

  // delayed copy to find the end of a bus reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_d1_q <= 1'b0;
    end else begin
      reset_d1_q <= link.bus_reset;
    end
  end

  assign reset_end = reset_d1_q & ~link.bus_reset;

  ////////////////////////////////////////////////////////////////////////////
  // enable register

  // software writes, hardware sets end-of-reset enable; the set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= UFS_ENABLE_RST;
    end else begin
      if (wr_enable) begin
        enable_q <= hwdata & UFS_EVENT_MASK;
      end
      if (reset_end) begin
        enable_q[UFS_BIT_RSTDONE] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status register

  assign clr_bits = wr_clear ? (hwdata & UFS_CLEAR_MASK) : 32'h00000000;

  // sticky event bits; other than wake they need the controller clock
  always_comb begin
    set_bits                  = 32'h00000000;
    set_bits[UFS_BIT_SUSPEND] = ctrl_clk_on & suspend_ev;
    set_bits[UFS_BIT_USOF]    = ctrl_clk_on & usof_ev;
    set_bits[UFS_BIT_SOF]     = ctrl_clk_on & sof_ev;
    set_bits[UFS_BIT_RSTDONE] = ctrl_clk_on & reset_end;
    set_bits[UFS_BIT_WAKE]    = wake_ev;
    set_bits[UFS_BIT_RSMDONE] = ctrl_clk_on & link.resume_end;
    set_bits[UFS_BIT_UPRES]   = ctrl_clk_on & link.up_resume;
  end

  // sticky bits: a set in the same cycle as a clear wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q[7:1] <= 7'h00;
    end else begin
      status_q[7:1] <= (status_q[7:1] & ~clr_bits[7:1]) | set_bits[7:1];
    end
  end

  // speed reflects the current link speed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q[UFS_BIT_SPEED] <= 1'b0;
    end else begin
      status_q[UFS_BIT_SPEED] <= link.high_speed;
    end
  end

  // endpoint bits follow their enabled source level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q[UFS_BIT_EP_LO +: UFS_NUM_EP] <= '0;
    end else begin
      status_q[UFS_BIT_EP_LO +: UFS_NUM_EP] <=
        ep_irq & enable_q[UFS_BIT_EP_LO +: UFS_NUM_EP];
    end
  end

  // dma bits follow their enabled channel level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q[UFS_BIT_DMA_LO +: UFS_NUM_DMA] <= '0;
    end else begin
      status_q[UFS_BIT_DMA_LO +: UFS_NUM_DMA] <=
        dma_irq & enable_q[UFS_BIT_DMA_LO +: UFS_NUM_DMA];
    end
  end

  // unused positions always read zero
  assign status_q[UFS_BIT_EP_LO+UFS_NUM_EP +: 10] = 10'h000;
  assign status_q[31] = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt

  // or of every status bit whose enable is set; speed has no enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & enable_q & UFS_EVENT_MASK);
    end
  end

  assign irq = irq_q;

  // hsize is always a full word here
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize};

endmodule

`default_nettype wire

// ===== tb/ufs_event_ctrl_assertions.sv
// port checker of the usb event block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ufs_event_ctrl_chk
  import ufs_pkg::*;
#(
  parameter int SUSPEND_CYCLES = UFS_SUSPEND_CYC,
  parameter int MICRO_CYCLES   = UFS_MICRO_CYCLES
) (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic [31:0]            hrdata,
  input wire ufs_link_t              link,
  input wire ufs_line_t              line,
  input wire logic                   ctrl_clk_on,
  input wire logic [UFS_NUM_EP-1:0]  ep_irq,
  input wire logic [UFS_NUM_DMA-1:0] dma_irq,
  input wire logic                   irq
);
  logic        ph_q;    // a data phase is under way
  logic        wr_q;    // that phase is a write
  logic [31:0] ad_q;    // its address
  logic [31:0] en_q;    // enable register as software wrote it
  int          idle_q;  // idle cycles with the clock on
  wire         wr_en = ph_q && wr_q && ad_q == UFS_ADDR_ENABLE;
  wire         rd_en = ph_q && !wr_q && ad_q == UFS_ADDR_ENABLE;
  wire         rd_st = ph_q && !wr_q && ad_q == UFS_ADDR_STATUS;
  wire         rd_cl = ph_q && !wr_q && ad_q == UFS_ADDR_CLEAR;
  ////////////////////////////////////////////////////////////////////////////
  // follow address phases taken by the slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 32'h0;
    end else if (hready) begin
      ph_q <= hsel && htrans[1];
      wr_q <= hwrite;
      ad_q <= haddr;
    end
  end
  // enable shadow; the automatic end-of-reset bit is not followed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      en_q <= 32'h0;
    else if (wr_en)
      en_q <= hwdata & UFS_EVENT_MASK;
  end
  // length of the present idle spell
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      idle_q <= 0;
    else if (line.idle_j && ctrl_clk_on)
      idle_q <= idle_q + 1;
    else
      idle_q <= 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_CLEAR_READS_ZERO: assert property (rd_cl |-> hrdata == 32'h0)
    else $error("clear register read back nonzero");
  AST_ENABLE_FIELDS: assert property (rd_en |-> (hrdata & ~UFS_EVENT_MASK) == 32'h0)
    else $error("enable read shows bits that do not exist");
  AST_SPEED_BIT: assert property (rd_st && link.high_speed == $past(link.high_speed)
    && link.high_speed == $past(link.high_speed, 2) |-> hrdata[UFS_BIT_SPEED] == link.high_speed)
    else $error("speed bit differs from link speed");
  AST_IRQ_OFF: assert property (wr_en && hwdata == 32'h0 |=> ##1 !irq)
    else $error("interrupt stayed up with all enables off");
  AST_SOF_IRQ: assert property (link.sof_seen && ctrl_clk_on && en_q[UFS_BIT_SOF] && !wr_en
    |-> ##2 irq)
    else $error("enabled frame start raised no interrupt");
  AST_EP_IRQ: assert property (ep_irq[0] && ctrl_clk_on && en_q[UFS_BIT_EP_LO] && !wr_en
    |-> ##2 irq)
    else $error("enabled endpoint raised no interrupt");
  AST_DMA_IRQ: assert property (dma_irq[UFS_NUM_DMA-1] && ctrl_clk_on && !wr_en
    && en_q[UFS_BIT_DMA_LO+UFS_NUM_DMA-1] |-> ##2 irq)
    else $error("enabled channel raised no interrupt");
  AST_SUSPEND_IRQ: assert property (idle_q == SUSPEND_CYCLES + 6
    && en_q[UFS_BIT_SUSPEND] |-> irq)
    else $error("idle line gave no suspend interrupt");
  cover property (link.sof_seen ##2 irq);
  cover property (idle_q == SUSPEND_CYCLES);
  cover property (rd_st && idle_q < MICRO_CYCLES);
endmodule

bind ufs_event_ctrl ufs_event_ctrl_chk #(
  .SUSPEND_CYCLES(SUSPEND_CYCLES),
  .MICRO_CYCLES  (MICRO_CYCLES)
) ufs_event_ctrl_chk_inst (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .link, .line, .ctrl_clk_on, .ep_irq, .dma_irq, .irq
);
`default_nettype wire

// ===== tb/ufs_host_model.sv
// behavioural host on the far side of the usb link
`timescale 1ns/1ps
`default_nettype none
module ufs_host_model
  import ufs_pkg::*;
(
  input  wire logic    hclk,
  output var ufs_link_t link,
  output var ufs_line_t line
);
  // quiet link at time zero
  initial begin
    link = '0;
    line = '0;
  end
  // one frame packet for a cycle, then released lines show the inverse
  task automatic pkt(input logic s, u, c, input logic [UFS_FRAME_W-1:0] f);
    link.sof_seen <= s;
    link.usof_seen <= u;
    link.crc_bad <= c;
    link.frame_num <= f;
    @(posedge hclk);
    link.sof_seen <= 1'b0;
    link.usof_seen <= 1'b0;
    link.crc_bad <= ~c;
    link.frame_num <= ~f;
    @(posedge hclk);
  endtask
  // bus reset held for n cycles
  task automatic bus_reset(input int n);
    link.bus_reset <= 1'b1;
    repeat (n) @(posedge hclk);
    link.bus_reset <= 1'b0;
  endtask
  // good end of a resume from the host
  task automatic resume_end;
    link.resume_end <= 1'b1;
    @(posedge hclk);
    link.resume_end <= 1'b0;
  endtask
  // speed, upstream resume and line levels
  task automatic levels(input logic hs, up, j, ni);
    link.high_speed <= hs;
    link.up_resume <= up;
    line.idle_j <= j;
    line.non_idle <= ni;
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the usb event block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ufs_pkg::*;
  localparam int SUSP = 50;   // shortened idle time before suspend
  localparam int MIC  = 200;  // shortened microframe period
  logic                   hclk, hresetn, hsel, hwrite, ctrl_clk_on, rd_pend;
  logic [31:0]            haddr, hwdata, v;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [UFS_NUM_EP-1:0]  ep_irq;
  logic [UFS_NUM_DMA-1:0] dma_irq;
  wire logic [31:0]       hrdata;
  wire logic              hreadyout, hresp, irq, hready;
  wire ufs_link_t         link;
  wire ufs_line_t         line;
  int                     miscompares, checked, seed;
  logic [63:0]            notes[$];  // mask and expected value of each read
  assign hready = hreadyout;
  ufs_event_ctrl #(.SUSPEND_CYCLES(SUSP), .MICRO_CYCLES(MIC)) ufs_event_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link), .line(line),
    .ctrl_clk_on(ctrl_clk_on), .ep_irq(ep_irq), .dma_irq(dma_irq), .irq(irq));
  ufs_host_model ufs_host_model_inst (.hclk(hclk), .link(link), .line(line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for hready high at a rising edge, bounded
  task automatic step_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      conclude();
    end
  endtask
  // one single ahb-lite word transfer; reads note their expectation
  task automatic bus(input logic w, input logic [31:0] a, d = 32'h0, m = 32'h0, e = 32'h0);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    step_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_pend <= !w;
    if (!w)
      notes.push_back({m, e});
    step_ready();
    rd_pend <= 1'b0;
  endtask
  // bounded wait for the interrupt
  task automatic wait_irq(input int n);
    int i;
    i = 0;
    while (irq !== 1'b1 && i < n) begin
      @(posedge hclk);
      i++;
    end
    if (i >= n) begin
      miscompares++;
      conclude();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // monitor: read data against the oldest note
  always @(posedge hclk) begin
    if (rd_pend && hready === 1'b1) begin
      check(hrdata & notes[0][63:32], notes[0][31:0]);
      check({31'h0, hresp}, 32'h0);
      void'(notes.pop_front());
    end
  end
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    conclude();
  end
  initial begin
    {hresetn, hsel, hwrite, rd_pend, ep_irq, dma_irq} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    ctrl_clk_on = 1'b1;
    seed = 32'h2dc3;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, UFS_ADDR_ENABLE, 0, 32'hffffffff, 0);
    bus(0, UFS_ADDR_CLEAR, 0, 32'hffffffff, 0);
    bus(0, 32'hfff78020, 0, 32'hffffffff, 0);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'hffffffff : $random(seed);
      bus(1, UFS_ADDR_ENABLE, v);
      bus(0, UFS_ADDR_ENABLE, 0, 32'hffffffff, v & UFS_EVENT_MASK);
    end
    bus(1, UFS_ADDR_ENABLE, 32'h0);
    bus(1, UFS_ADDR_STATUS, 32'hffffffff);
    bus(0, UFS_ADDR_STATUS, 0, 32'hffffffff, 0);
    // frames in high speed
    ufs_host_model_inst.levels(1, 0, 0, 0);
    bus(1, UFS_ADDR_ENABLE, 32'h8);
    ufs_host_model_inst.pkt(1, 0, 0, 11'h5a3);
    wait_irq(4);
    bus(0, UFS_ADDR_FRAME, 0, 32'hffffffff, 32'h5a3 << UFS_FRAME_LO);
    bus(0, UFS_ADDR_STATUS, 0, 32'hf, 32'h9);
    ufs_host_model_inst.pkt(0, 1, 0, 11'h111);
    ufs_host_model_inst.pkt(0, 1, 1, 11'h222);
    v = (32'h1 << UFS_BIT_FERR) | (32'h5a3 << UFS_FRAME_LO) | 32'h2;
    bus(0, UFS_ADDR_FRAME, 0, 32'hffffffff, v);
    bus(1, UFS_ADDR_CLEAR, 32'hfe);
    ufs_host_model_inst.pkt(1, 1, 0, 11'h7ff);
    bus(0, UFS_ADDR_STATUS, 0, 32'hc, 32'h8);
    bus(0, UFS_ADDR_FRAME, 0, 32'hffffffff, 32'h7ff << UFS_FRAME_LO);
    bus(1, UFS_ADDR_CLEAR, 32'hfe);
    repeat (MIC + 10) @(posedge hclk);
    bus(0, UFS_ADDR_STATUS, 0, 32'h4, 32'h4);
    // resume events, clear by write-one only
    bus(1, UFS_ADDR_ENABLE, 32'h0);
    ufs_host_model_inst.resume_end();
    ufs_host_model_inst.levels(1, 1, 0, 0);
    bus(1, UFS_ADDR_CLEAR, 32'h0);
    bus(0, UFS_ADDR_STATUS, 0, 32'hc0, 32'hc0);
    check({31'h0, irq}, 32'h0);
    ufs_host_model_inst.levels(1, 0, 0, 0);
    bus(1, UFS_ADDR_CLEAR, 32'hc0);
    bus(0, UFS_ADDR_STATUS, 0, 32'hc0, 32'h0);
    // end of bus reset
    ufs_host_model_inst.bus_reset(5);
    bus(0, UFS_ADDR_CLEAR, 0, 32'hffffffff, 0);
    bus(0, UFS_ADDR_ENABLE, 0, 32'h10, 32'h10);
    bus(0, UFS_ADDR_STATUS, 0, 32'h10, 32'h10);
    // endpoint and channel sources against a partial enable
    bus(1, UFS_ADDR_ENABLE, 32'h52005d00);
    for (int i = 0; i < 3; i++) begin
      v = (i == 2) ? 32'h0 : $random(seed) | 32'h40000100;
      ep_irq <= v[14:8];
      dma_irq <= v[30:25];
      @(posedge hclk);
      bus(0, UFS_ADDR_STATUS, 0, 32'h7e007f00, v & 32'h52005d00);
    end
    // suspend, then wake with the controller clock off
    bus(1, UFS_ADDR_CLEAR, 32'hfe);
    bus(1, UFS_ADDR_ENABLE, 32'h22);
    ufs_host_model_inst.levels(1, 0, 1, 0);
    repeat (SUSP) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wait_irq(20);
    bus(0, UFS_ADDR_STATUS, 0, 32'h22, 32'h2);
    bus(1, UFS_ADDR_CLEAR, 32'h2);
    bus(0, UFS_ADDR_STATUS, 0, 32'h22, 32'h0);
    ctrl_clk_on <= 1'b0;
    ufs_host_model_inst.levels(1, 0, 0, 1);
    wait_irq(20);
    ctrl_clk_on <= 1'b1;
    ufs_host_model_inst.levels(1, 0, 0, 0);
    bus(0, UFS_ADDR_STATUS, 0, 32'h22, 32'h20);
    conclude();
  end
endmodule
`default_nettype wire
